// file: sdg_dma_ctrl.sv
// Controller end: channel enables, arbitration, descriptor fetch and
// peripheral scatter-gather sequencing over the AHB-Lite master.
// Assumes a single-beat non-pipelined slave on the same clock.
`default_nettype none

module sdg_dma_ctrl
  import sdg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  sdg_link_if.ctrl               link,
  input  wire logic [ADDR_W-1:0] ctrlBasePtr,
  output logic      [ADDR_W-1:0] altCtrlBasePtr,
  input  wire logic [NCH-1:0]    chnlEnableSet,
  input  wire logic [NCH-1:0]    chnlEnableClr,
  output logic      [NCH-1:0]    chnlEnable
);
  sdg_state_t        state_ff;
  sdg_state_t        nxt_state;
  logic [CH_W-1:0]   ch_ff;
  logic              alt_ff;
  logic [NCH-1:0]    chAlt_ff;
  logic [1:0]        elem_ff;
  logic [DATA_W-1:0] srcEnd_ff;
  logic [DATA_W-1:0] dstEnd_ff;
  logic [DATA_W-1:0] cfg_ff;
  logic [CNT_W-1:0]  left_ff;
  logic [CNT_W-1:0]  batch_ff;
  logic [DATA_W-1:0] dataBuf_ff;
  logic              last_ff;
  logic [NCH-1:0]    done_ff;
  logic              err_ff;
  logic [NCH-1:0]    enable_ff;

  logic              grantValid;
  logic [CH_W-1:0]   grantCh;
  logic [2:0]        mode;
  logic [3:0]        rPow;
  logic [ELEM_W-1:0] elemOff;
  logic [ADDR_W-1:0] descAddr;
  logic [ADDR_W-1:0] srcAddr;
  logic [ADDR_W-1:0] dstAddr;
  logic              busDone;
  logic              busErr;
  logic              xferEnd;
  logic              stopEvt;
  logic              doneEvt;
  logic [NCH-1:0]    clrVec;

  assign mode    = cfg_ff[CYC_MSB:CYC_LSB];
  assign rPow    = cfg_ff[R_MSB:R_LSB];
  assign busDone = link.hready && !link.hresp;
  assign busErr  = link.hready && link.hresp;
  assign xferEnd = (left_ff == '0) || (batch_ff == '0);

  // ====================================================
  // Descriptor addressing
  always_comb begin
    elemOff = ELEM_SRC;
    if (elem_ff == 2'h1) begin
      elemOff = ELEM_DST;
    end else if (elem_ff == FET_LAST) begin
      elemOff = ELEM_CFG; // RULE15 RULE16
    end
  end

  // Low base bits are dropped, so a misaligned base cannot corrupt others
  assign descAddr = {ctrlBasePtr[ADDR_W-1:BASE_LSB], alt_ff, ch_ff, elemOff}; // RULE13 RULE14 RULE17 RULE24

  assign srcAddr = (cfg_ff[SINC_MSB:SINC_LSB] == INC_NONE) ? srcEnd_ff
                 : srcEnd_ff - ADDR_W'({left_ff, 2'b00});
  assign dstAddr = (cfg_ff[DINC_MSB:DINC_LSB] == INC_NONE) ? dstEnd_ff
                 : dstEnd_ff - ADDR_W'({left_ff, 2'b00});

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      altCtrlBasePtr <= '0;
    end else begin
      altCtrlBasePtr <= {ctrlBasePtr[ADDR_W-1:BASE_LSB], 1'b1, {ALT_BIT{1'b0}}}; // RULE18
    end
  end

  // ====================================================
  // Arbitration: lowest channel index wins
  always_comb begin
    grantValid = 1'b0;
    grantCh    = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (enable_ff[i] && link.dmaReq[i]) begin // RULE2 RULE4
        grantValid = 1'b1;
        grantCh    = CH_W'(i);
      end
    end
  end

  // ====================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:   if (grantValid) begin
        nxt_state = ST_FET_A;
      end
      ST_FET_A:  nxt_state = ST_FET_D;
      ST_FET_D:  if (busErr) begin
        nxt_state = ST_IDLE;
      end else if (busDone) begin
        nxt_state = (elem_ff == FET_LAST) ? ST_DECIDE : ST_FET_A;
      end
      ST_DECIDE: nxt_state = (mode == CYC_STOP) ? ST_IDLE : ST_RD_A; // RULE23
      ST_RD_A:   nxt_state = ST_RD_D;
      ST_RD_D:   if (busErr) begin
        nxt_state = ST_IDLE;
      end else if (busDone) begin
        nxt_state = ST_WR_A;
      end
      ST_WR_A:   nxt_state = ST_WR_D;
      ST_WR_D:   if (busErr) begin
        nxt_state = ST_IDLE;
      end else if (busDone) begin
        nxt_state = xferEnd ? ST_WB_A : ST_RD_A; // RULE3
      end
      ST_WB_A:   nxt_state = ST_WB_D;
      ST_WB_D:   if (busErr) begin
        nxt_state = ST_IDLE;
      end else if (busDone) begin
        nxt_state = (mode == CYC_PSG_PRI) ? ST_FET_A : ST_IDLE; // RULE22 RULE4
      end
      default:   nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ====================================================
  // Channel and descriptor select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ch_ff   <= '0;
      alt_ff  <= 1'b0;
      elem_ff <= '0;
    end else if (state_ff == ST_IDLE && grantValid) begin
      ch_ff   <= grantCh;
      alt_ff  <= chAlt_ff[grantCh];
      elem_ff <= '0;
    end else if (state_ff == ST_FET_D && busDone) begin
      elem_ff <= elem_ff + 2'h1;
    end else if (state_ff == ST_WB_D && busDone && mode == CYC_PSG_PRI) begin
      alt_ff  <= 1'b1; // RULE22
      elem_ff <= '0;
    end
  end

  // Descriptor words: two pointers and one control word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srcEnd_ff <= '0;
      dstEnd_ff <= '0;
      cfg_ff    <= '0;
    end else if (state_ff == ST_FET_D && busDone) begin
      case (elem_ff)
        2'h0:    srcEnd_ff <= link.hrdata; // RULE21
        2'h1:    dstEnd_ff <= link.hrdata;
        default: cfg_ff    <= link.hrdata;
      endcase
    end
  end

  // ====================================================
  // Transfer counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_ff  <= '0;
      batch_ff <= '0;
    end else if (state_ff == ST_DECIDE) begin
      left_ff  <= cfg_ff[N_MSB:N_LSB];
      batch_ff <= (rPow >= R_MAX) ? CNT_MAX : (CNT_ONE << rPow) - CNT_ONE; // RULE5
    end else if (state_ff == ST_WR_D && busDone && !xferEnd) begin
      left_ff  <= left_ff - CNT_ONE;
      batch_ff <= batch_ff - CNT_ONE;
    end
  end

  // Read data and control write-back share one write-data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dataBuf_ff <= '0;
      last_ff    <= 1'b0;
    end else if (state_ff == ST_RD_D && busDone) begin
      dataBuf_ff <= link.hrdata;
    end else if (state_ff == ST_WR_D && busDone && xferEnd) begin
      last_ff    <= (left_ff == '0);
      dataBuf_ff <= cfg_ff;
      dataBuf_ff[N_MSB:N_LSB] <= (left_ff == '0) ? left_ff : left_ff - CNT_ONE;
      if (left_ff == '0) begin
        dataBuf_ff[CYC_MSB:CYC_LSB] <= CYC_STOP; // RULE6
      end
    end
  end

  // ====================================================
  // Completion, error and enables
  assign stopEvt = (state_ff == ST_DECIDE) && (mode == CYC_STOP);
  assign doneEvt = (state_ff == ST_WB_D) && busDone && last_ff
                && (mode != CYC_PSG_PRI) && (mode != CYC_PSG_ALT); // RULE7

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= '0;
      err_ff  <= 1'b0;
    end else begin
      done_ff <= doneEvt ? (NCH'(1) << ch_ff) : '0; // RULE8
      err_ff  <= busErr && (state_ff inside {ST_FET_D, ST_RD_D, ST_WR_D, ST_WB_D}); // RULE9
    end
  end

  always_comb begin
    clrVec = '0;
    if (doneEvt || stopEvt || (err_ff == 1'b0 && busErr && state_ff != ST_IDLE)) begin
      clrVec[ch_ff] = 1'b1; // RULE9 RULE10
    end
  end

  // Software set wins over a same-cycle hardware clear
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_chan
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          enable_ff[g] <= 1'b0;
          chAlt_ff[g]  <= 1'b0;
        end else begin
          if (chnlEnableSet[g]) begin
            enable_ff[g] <= 1'b1;
          end else if (chnlEnableClr[g] || clrVec[g]) begin
            enable_ff[g] <= 1'b0;
          end
          if (CH_W'(g) == ch_ff && state_ff == ST_WB_D && busDone) begin
            chAlt_ff[g] <= (mode == CYC_PSG_PRI) || (!last_ff && alt_ff);
          end else if (chnlEnableSet[g] || clrVec[g]) begin
            chAlt_ff[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ====================================================
  // Link outputs
  assign chnlEnable     = enable_ff;
  assign link.dmaDone   = done_ff;
  assign link.dmaErr    = err_ff;
  assign link.dmaActive = (state_ff == ST_IDLE) ? '0 : (NCH'(1) << ch_ff); // RULE22
  assign link.hsize     = HSIZE_WORD;
  assign link.hwdata    = dataBuf_ff;

  always_comb begin
    link.htrans = HTRANS_IDLE;
    link.hwrite = 1'b0;
    link.haddr  = '0;
    case (state_ff)
      ST_FET_A: begin
        link.htrans = HTRANS_NONSEQ;
        link.haddr  = descAddr;
      end
      ST_RD_A: begin
        link.htrans = HTRANS_NONSEQ;
        link.haddr  = srcAddr;
      end
      ST_WR_A: begin
        link.htrans = HTRANS_NONSEQ;
        link.hwrite = 1'b1;
        link.haddr  = dstAddr;
      end
      ST_WB_A: begin
        link.htrans = HTRANS_NONSEQ;
        link.hwrite = 1'b1;
        link.haddr  = {descAddr[ADDR_W-1:ELEM_W], ELEM_CFG};
      end
      default: begin
        link.htrans = HTRANS_IDLE;
      end
    endcase
  end
endmodule

`default_nettype wire

// file: sdg_link_if.sv
// AHB-Lite master link plus per-channel request, done and active lines.
// Assumes both ends share one clock; the bench resolves nothing here.
`default_nettype none

interface sdg_link_if;
  import sdg_pkg::*;
  logic [ADDR_W-1:0] haddr;
  logic [1:0]        htrans;
  logic              hwrite;
  logic [2:0]        hsize;
  logic [DATA_W-1:0] hwdata;
  logic [DATA_W-1:0] hrdata;
  logic              hready;
  logic              hresp;
  logic [NCH-1:0]    dmaReq;
  logic [NCH-1:0]    dmaDone;
  logic [NCH-1:0]    dmaActive;
  logic              dmaErr;

  modport ctrl (output haddr, htrans, hwrite, hsize, hwdata, dmaDone, dmaActive, dmaErr,
                input  hrdata, hready, hresp, dmaReq);
  modport mem  (input  haddr, htrans, hwrite, hsize, hwdata, dmaDone, dmaActive, dmaErr,
                output hrdata, hready, hresp, dmaReq);
endinterface

`default_nettype wire

// file: sdg_link_props.sv
// Concurrent checks on the link between controller and memory end.
// Assumes one clock and a structure base that stays fixed while traffic runs.
`default_nettype none

module sdg_link_props
  import sdg_pkg::*;
#(
  parameter logic [ADDR_W-1:0] CTRL_BASE = 32'h0
)(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic              hready,
  input wire logic              hresp,
  input wire logic [NCH-1:0]    dmaReq,
  input wire logic [NCH-1:0]    dmaDone,
  input wire logic [NCH-1:0]    dmaActive,
  input wire logic              dmaErr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Helpers
  function automatic logic [CH_W-1:0] chIdx(input logic [NCH-1:0] v);
    chIdx = 5'h0;
    for (int i = 0; i < NCH; i++) if (v[i]) chIdx = CH_W'(i);
  endfunction

  logic addrPh;
  logic inPri;
  assign addrPh = htrans == HTRANS_NONSEQ;
  // Primary half only: the alternate half also receives copied data words
  assign inPri  = addrPh && haddr[ADDR_W-1:BASE_LSB] == CTRL_BASE[ADDR_W-1:BASE_LSB] && !haddr[ALT_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence errResp_s;
    hresp && !hready ##1 hresp && hready;
  endsequence
  sequence grant_s;
    dmaActive == 32'h0 ##1 dmaActive != 32'h0;
  endsequence

  // ==========================================================
  // Properties
  done_one_cycle_a: assert property (dmaDone != 32'h0 |=> dmaDone == 32'h0)
    else $error("completion pulse longer than one cycle");
  done_one_hot_a: assert property (dmaDone != 32'h0 |-> $onehot(dmaDone))
    else $error("completion on more than one channel");
  err_after_resp_a: assert property (errResp_s |-> ##[1:2] dmaErr)
    else $error("bus error output missing after error response");
  err_one_cycle_a: assert property (dmaErr |=> !dmaErr)
    else $error("bus error pulse too long");
  err_needs_resp_a: assert property ($rose(dmaErr) |-> $past(hresp, 1) || $past(hresp, 2))
    else $error("bus error output without error response");
  grant_on_req_a: assert property (grant_s |-> (dmaActive & $past(dmaReq)) != 32'h0)
    else $error("channel activated without its request");
  grant_fetch_addr_a: assert property (grant_s |-> addrPh
    && haddr[ADDR_W-1:BASE_LSB] == CTRL_BASE[ADDR_W-1:BASE_LSB]
    && haddr[ALT_BIT-1:ELEM_W] == chIdx(dmaActive) && haddr[ELEM_W-1:0] == ELEM_SRC)
    else $error("first descriptor fetch at wrong address");
  active_one_hot_a: assert property (dmaActive != 32'h0 |-> $onehot(dmaActive))
    else $error("more than one channel active");
  pri_no_unused_a: assert property (inPri |-> haddr[3:0] != 4'hc && haddr[1:0] == 2'h0)
    else $error("unused descriptor word accessed");
  pri_write_cfg_a: assert property (inPri && hwrite |-> haddr[ELEM_W-1:0] == ELEM_CFG)
    else $error("primary descriptor write outside control word");
  one_beat_a: assert property (addrPh |-> hsize == HSIZE_WORD ##1 htrans == HTRANS_IDLE)
    else $error("transfer not a single word beat");
endmodule

`default_nettype wire

// file: sdg_mem_periph.sv
// Far end: system memory as an AHB-Lite slave, peripheral requests,
// and the software view of done records and base alignment.
// Assumes the controller end runs on the same clock.
`default_nettype none

module sdg_mem_periph
  import sdg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  sdg_link_if.mem                link,
  input  wire logic [NCH-1:0]    periphReq,
  input  wire logic              hostWe,
  input  wire logic [MEM_AW-1:0] hostAddr,
  input  wire logic [DATA_W-1:0] hostWdata,
  output logic      [DATA_W-1:0] hostRdata,
  input  wire logic              errInject,
  input  wire logic [ADDR_W-1:0] errAddr,
  input  wire logic [NCH-1:0]    chnlEnableSts,
  input  wire logic              doneRecClr,
  input  wire logic [ADDR_W-1:0] basePtrChk,
  output logic      [NCH-1:0]    faultyCh,
  output logic                   baseAligned
);
  logic [DATA_W-1:0] mem [2**MEM_AW];
  logic              dpValid_ff;
  logic              dpWrite_ff;
  logic              dpErr_ff;
  logic [MEM_AW-1:0] dpAddr_ff;
  logic              errCyc_ff;
  logic [NCH-1:0]    doneRec_ff;
  logic              errSeen_ff;

  // ====================================================
  // Slave data phase
  assign link.dmaReq = periphReq;
  assign link.hresp  = dpValid_ff && dpErr_ff;
  assign link.hready = !(dpValid_ff && dpErr_ff && !errCyc_ff);
  assign link.hrdata = mem[dpAddr_ff];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dpValid_ff <= 1'b0;
      dpWrite_ff <= 1'b0;
      dpErr_ff   <= 1'b0;
      dpAddr_ff  <= '0;
    end else if (link.hready) begin
      dpValid_ff <= link.htrans[1];
      dpWrite_ff <= link.hwrite;
      dpErr_ff   <= errInject && (link.haddr[ADDR_W-1:2] == errAddr[ADDR_W-1:2]);
      dpAddr_ff  <= link.haddr[MEM_AW+1:2];
    end
  end

  // Two-cycle ERROR: first with hready low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errCyc_ff <= 1'b0;
    end else begin
      errCyc_ff <= dpValid_ff && dpErr_ff && !errCyc_ff;
    end
  end

  // Bus writes win over host writes; memory holds no reset
  always_ff @(posedge clk) begin
    if (dpValid_ff && dpWrite_ff && !dpErr_ff) begin
      mem[dpAddr_ff] <= link.hwdata;
    end else if (hostWe) begin
      mem[hostAddr] <= hostWdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hostRdata <= '0;
    end else begin
      hostRdata <= mem[hostAddr];
    end
  end

  // ====================================================
  // Software bookkeeping
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      doneRec_ff <= '0;
      errSeen_ff <= 1'b0;
    end else begin
      doneRec_ff <= link.dmaDone | (doneRecClr ? '0 : doneRec_ff);
      errSeen_ff <= link.dmaErr || (errSeen_ff && !doneRecClr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      faultyCh <= '0;
    end else begin
      faultyCh <= errSeen_ff ? (~chnlEnableSts & ~doneRec_ff) : '0; // RULE11
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baseAligned <= 1'b0;
    end else begin
      baseAligned <= (basePtrChk[BASE_LSB-1:0] == '0); // RULE12 RULE20
    end
  end
endmodule

`default_nettype wire

// file: sdg_pkg.sv
// Constants, field layouts and states shared by both ends of the
// scatter-gather DMA link.
// Assumes one 40 MHz clock and word-only transfers.
// Functional notes
// RULE1 - Software sets primary mode b110, batch four
// RULE2 - Transaction starts only on peripheral request
// RULE3 - Four primary copies write next alternate descriptor
// RULE4 - After alternate task, rearbitrate on new request
// RULE5 - Peripheral requests again for each remaining batch
// RULE6 - Final copy rewrites primary mode to b000
// RULE7 - Last task runs as basic cycle
// RULE8 - Completion pulse one cycle, then arbitrate
// RULE9 - Bus ERROR disables channel, raises error output
// RULE10 - Completion also clears channel enable
// RULE11 - Software finds disabled channel without completion
// RULE12 - Structure contiguous, base aligned to size
// RULE13 - 32 channels: 1KB, ten address bits
// RULE14 - Channel index from bit 4, select above
// RULE15 - Element offsets: source, destination, control
// RULE16 - Offset 0xC never accessed by controller
// RULE17 - Primary base comes from base register
// RULE18 - Alternate base readable, no software arithmetic
// RULE19 - Three channels: 128 bytes, seven bits
// RULE20 - Base alignment scales with channel count
// RULE21 - Descriptor: two pointers, one control word
// RULE22 - Primary copy flows into alternate, stays active
// RULE23 - Mode b000 means stop, ends sequence
// RULE24 - Fetch address by concatenation, no adder
`default_nettype none

package sdg_pkg;
  // ====================================================
  // Sizes
  localparam int NCH      = 32;
  localparam int CH_W     = 5;
  localparam int ADDR_W   = 32;
  localparam int DATA_W   = 32;
  localparam int ELEM_W   = 4;
  localparam int BASE_LSB = ELEM_W + CH_W + 1; // RULE19 RULE20
  localparam int ALT_BIT  = BASE_LSB - 1;
  localparam int CNT_W    = 10;
  localparam int MEM_AW   = 9;

  // ====================================================
  // Descriptor elements
  localparam logic [ELEM_W-1:0] ELEM_SRC = 4'h0;
  localparam logic [ELEM_W-1:0] ELEM_DST = 4'h4;
  localparam logic [ELEM_W-1:0] ELEM_CFG = 4'h8;
  localparam logic [1:0]        FET_LAST = 2'h2;

  // ====================================================
  // Control word fields
  localparam int CYC_LSB = 0;
  localparam int CYC_MSB = 2;
  localparam int N_LSB   = 4;
  localparam int N_MSB   = 13;
  localparam int R_LSB   = 14;
  localparam int R_MSB   = 17;
  localparam int SINC_LSB = 26;
  localparam int SINC_MSB = 27;
  localparam int DINC_LSB = 30;
  localparam int DINC_MSB = 31;

  localparam logic [2:0] CYC_STOP    = 3'h0;
  localparam logic [2:0] CYC_BASIC   = 3'h1;
  localparam logic [2:0] CYC_PSG_PRI = 3'h6;
  localparam logic [2:0] CYC_PSG_ALT = 3'h7;
  localparam logic [1:0] INC_NONE    = 2'h3;
  localparam logic [3:0] R_MAX       = 4'ha;
  localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;

  // ====================================================
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_FET_A  = 4'h1,
    ST_FET_D  = 4'h2,
    ST_DECIDE = 4'h3,
    ST_RD_A   = 4'h4,
    ST_RD_D   = 4'h5,
    ST_WR_A   = 4'h6,
    ST_WR_D   = 4'h7,
    ST_WB_A   = 4'h8,
    ST_WB_D   = 4'h9
  } sdg_state_t;
endpackage

`default_nettype wire

// file: test_dma_descriptor_scatter_gather.sv
// Self-checking bench joining controller and memory end over the link.
// Assumes the structure lives at BASE and task data above it in memory.
`default_nettype none

module test_dma_descriptor_scatter_gather
  import sdg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [ADDR_W-1:0] BASE = 32'h2000_0000;
  logic              clk, rst_n, hostWe, errInject, doneRecClr, baseAligned, errAcc, accClr;
  logic [NCH-1:0]    periphReq, chnlEnableSet, chnlEnableClr, chnlEnable, faultyCh, doneAcc;
  logic [MEM_AW-1:0] hostAddr;
  logic [DATA_W-1:0] hostWdata, hostRdata, rd, sentinel;
  logic [ADDR_W-1:0] ctrlBasePtr, altCtrlBasePtr, errAddr, basePtrChk;
  logic [DATA_W-1:0] srcData [8];
  int                seed = 36;
  int                badCount, testsRun, chA, chB, chE, n;

  sdg_link_if i_sdg_link_if ();
  sdg_dma_ctrl i_sdg_dma_ctrl (.clk(clk), .rst_n(rst_n), .link(i_sdg_link_if), .ctrlBasePtr(ctrlBasePtr),
    .altCtrlBasePtr(altCtrlBasePtr), .chnlEnableSet(chnlEnableSet), .chnlEnableClr(chnlEnableClr),
    .chnlEnable(chnlEnable));
  sdg_mem_periph i_sdg_mem_periph (.clk(clk), .rst_n(rst_n), .link(i_sdg_link_if), .periphReq(periphReq),
    .hostWe(hostWe), .hostAddr(hostAddr), .hostWdata(hostWdata), .hostRdata(hostRdata), .errInject(errInject),
    .errAddr(errAddr), .chnlEnableSts(chnlEnable), .doneRecClr(doneRecClr), .basePtrChk(basePtrChk),
    .faultyCh(faultyCh), .baseAligned(baseAligned));
  sdg_link_props #(.CTRL_BASE(BASE)) i_sdg_link_props (.clk(clk), .rst_n(rst_n), .haddr(i_sdg_link_if.haddr),
    .htrans(i_sdg_link_if.htrans), .hwrite(i_sdg_link_if.hwrite), .hsize(i_sdg_link_if.hsize),
    .hready(i_sdg_link_if.hready), .hresp(i_sdg_link_if.hresp), .dmaReq(i_sdg_link_if.dmaReq),
    .dmaDone(i_sdg_link_if.dmaDone), .dmaActive(i_sdg_link_if.dmaActive), .dmaErr(i_sdg_link_if.dmaErr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Completion and error are single-cycle pulses, so they are collected
  always @(posedge clk) begin
    doneAcc <= accClr ? '0 : doneAcc | i_sdg_link_if.dmaDone;
    errAcc  <= accClr ? 1'b0 : errAcc | i_sdg_link_if.dmaErr;
  end

  // ==========================================================
  // Tasks
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic finishTest();
    $display("comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic memW(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    hostAddr = a[MEM_AW+1:2];
    hostWdata = d;
    hostWe = 1'b1;
    tick(1);
    hostWe = 1'b0;
    tick(1);
  endtask
  task automatic memR(input logic [ADDR_W-1:0] a);
    hostAddr = a[MEM_AW+1:2];
    tick(1);
    rd = hostRdata;
  endtask
  task automatic pulseEn(input logic [NCH-1:0] s, input logic [NCH-1:0] c);
    chnlEnableSet = s;
    chnlEnableClr = c;
    tick(1);
    chnlEnableSet = 32'h0;
    chnlEnableClr = 32'h0;
    tick(1);
  endtask
  task automatic clrAcc();
    accClr = 1'b1;
    tick(1);
    accClr = 1'b0;
  endtask
  function automatic logic [31:0] cfgWord(input logic [3:0] r, input int cnt, input logic [2:0] mode);
    cfgWord = {2'h2, 2'h2, 2'h2, 2'h2, 6'h0, r, 10'(cnt - 1), 1'b0, mode};
  endfunction
  function automatic logic [31:0] altOf(input int ch);
    altOf = BASE + 32'h200 + 32'(ch * 16);
  endfunction
  // Primary copies one four-word task descriptor from region k
  task automatic load(input int ch, input int k, input int cnt, input logic [3:0] r, input logic [2:0] mode);
    logic [ADDR_W-1:0] pri, tab;
    pri = BASE + 32'(ch * 16);
    tab = BASE + 32'h400 + 32'(k * 256);
    memW(pri, tab + 32'hc);
    memW(pri + 32'h4, altOf(ch) + 32'hc);
    memW(pri + 32'h8, cfgWord(4'h2, 4, CYC_PSG_PRI));
    memW(pri + 32'hc, sentinel);
    memW(tab, tab + 32'h40 + 32'(4 * (cnt - 1)));
    memW(tab + 32'h4, tab + 32'h80 + 32'(4 * (cnt - 1)));
    memW(tab + 32'h8, cfgWord(r, cnt, mode));
    memW(tab + 32'hc, 32'h0);
    for (int i = 0; i < cnt; i++) begin
      srcData[i] = $random(seed);
      memW(tab + 32'h40 + 32'(4 * i), srcData[i]);
      memW(tab + 32'h80 + 32'(4 * i), ~srcData[i]);
    end
  endtask
  task automatic verify(input int k, input int cnt, input int done);
    for (int i = 0; i < cnt; i++) begin
      memR(BASE + 32'h480 + 32'(k * 256 + 4 * i));
      check(rd, (i < done) ? srcData[i] : ~srcData[i]);
    end
  endtask
  task automatic checkDesc(input int ch, input int k, input int cnt);
    memR(BASE + 32'(ch * 16) + 32'h8);
    check({29'h0, rd[2:0]}, {29'h0, CYC_STOP});
    memR(BASE + 32'(ch * 16) + 32'hc);
    check(rd, sentinel);
    memR(altOf(ch));
    check(rd, BASE + 32'h440 + 32'(k * 256 + 4 * (cnt - 1)));
    memR(altOf(ch) + 32'h4);
    check(rd, BASE + 32'h480 + 32'(k * 256 + 4 * (cnt - 1)));
  endtask
  // One request, held until taken, then wait for the channel to go idle
  task automatic serve(input int ch);
    int w;
    w = 0;
    periphReq[ch] = 1'b1;
    while (i_sdg_link_if.dmaActive[ch] !== 1'b1 && w < 50) begin
      tick(1);
      w++;
    end
    periphReq[ch] = 1'b0;
    if (i_sdg_link_if.dmaActive[ch] !== 1'b1) w = 401;
    while (i_sdg_link_if.dmaActive !== 32'h0 && w < 400) begin
      tick(1);
      w++;
    end
    if (w > 400 || i_sdg_link_if.dmaActive !== 32'h0) begin
      badCount++;
      finishTest();
    end
    tick(3);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {periphReq, chnlEnableSet, chnlEnableClr} = '0;
    {hostWe, errInject, doneRecClr, accClr} = 4'h1;
    hostAddr = 9'h0;
    hostWdata = 32'h0;
    errAddr = 32'h0;
    ctrlBasePtr = BASE;
    basePtrChk = 32'h0;
    sentinel = $random(seed);
    tick(16);
    rst_n = 1'b1;
    tick(2);
    for (int i = 0; i < 6; i++) begin
      ctrlBasePtr = (i == 0) ? 32'hffff_fc00 : ($random(seed) & 32'hffff_fc00);
      basePtrChk = (i == 0) ? 32'h200 : ($random(seed) & (i[0] ? 32'hffff_fc00 : 32'hffff_ffff));
      tick(2);
      check(altCtrlBasePtr, ctrlBasePtr | 32'h200);
      check({31'h0, baseAligned}, {31'h0, basePtrChk[9:0] == 10'h0});
    end
    ctrlBasePtr = BASE;
    tick(2);
    $display("test base pointers done");
    chB = $random(seed) & 31;
    chA = (chB + 7) % 32;
    chE = (chB + 13) % 32;
    load(chB, 0, 8, 4'h1, CYC_PSG_ALT);
    clrAcc();
    pulseEn(32'(1) << chB, 32'h0);
    pulseEn(32'h0, 32'(1) << chB);
    periphReq[chB] = 1'b1;
    tick(6);
    check(i_sdg_link_if.dmaActive, 32'h0);
    periphReq[chB] = 1'b0;
    pulseEn(32'(1) << chB, 32'h0);
    for (int i = 1; i <= 4; i++) begin
      serve(chB);
      verify(0, 8, 2 * i);
      check(chnlEnable, 32'(1) << chB);
    end
    check(doneAcc, 32'h0);
    serve(chB);
    check(chnlEnable, 32'h0);
    check({doneAcc[30:0], errAcc}, 32'h0);
    checkDesc(chB, 0, 8);
    $display("test peripheral sequence done");
    doneRecClr = 1'b1;
    tick(1);
    doneRecClr = 1'b0;
    pulseEn(32'hffff_ffff, 32'h0);
    n = 1 + ($random(seed) & 3);
    load(chA, 1, n, 4'h2, CYC_BASIC);
    // Fixed source: every transfer copies the last source word
    memW(BASE + 32'h508, cfgWord(4'h2, n, CYC_BASIC) | 32'h0c00_0000);
    for (int i = 0; i < n; i++) srcData[i] = srcData[n - 1];
    clrAcc();
    serve(chA);
    check(doneAcc, 32'(1) << chA);
    check(chnlEnable, ~(32'(1) << chA));
    verify(1, n, n);
    checkDesc(chA, 1, n);
    load(chE, 2, 4, 4'h2, CYC_BASIC);
    errAddr = BASE + 32'h640;
    errInject = 1'b1;
    clrAcc();
    serve(chE);
    errInject = 1'b0;
    check({doneAcc[30:0], errAcc}, 32'h1);
    check(chnlEnable, ~((32'(1) << chA) | (32'(1) << chE)));
    check(faultyCh, 32'(1) << chE);
    $display("test completion and error done");
    finishTest();
  end
endmodule

`default_nettype wire
